// File: ttt_pkg.sv
// Constants for the tick-scanned timer table
package ttt_pkg;
    localparam int TTT_N = 16;
    localparam logic [3:0] TTT_A_EVENTS = 4'h0;
    localparam logic [3:0] TTT_A_MASK = 4'h1;
    localparam logic [3:0] TTT_A_CMD_PARAM = 4'h2;
    localparam logic [3:0] TTT_A_CMD = 4'h3;
    localparam logic [3:0] TTT_A_CONFIG = 4'h4;
    localparam logic [3:0] TTT_A_TALLY = 4'h5;
    localparam logic [3:0] TTT_A_VALID = 4'h6;
    localparam logic [3:0] TTT_A_RESTART = 4'h7;
    localparam logic [3:0] TTT_A_CPM_MASK = 4'h8;
    localparam logic [3:0] TTT_A_CPM_PEND = 4'h9;
    localparam logic [3:0] TTT_A_ENTRY = 4'ha;
    localparam logic [15:0] TTT_SET_TIMER = 16'h0851;
    localparam int TTT_P_VALID = 31;
    localparam int TTT_P_RESTART = 30;
    localparam int TTT_P_NUM_LO = 16;
    localparam int TTT_CFG_ENABLE = 6;
    localparam int TTT_TICK_UNIT = 1024;
    localparam logic [15:0] TTT_RST16 = 16'h0000;
    localparam logic [31:0] TTT_RST32 = 32'h0000_0000;
    localparam logic [6:0] TTT_RST_CFG = 7'h00;
endpackage

// File: ttt_prescaler.sv
// Tick prescaler: one tick every (field+1)*1024 clocks
`timescale 1ns/1ps
`default_nettype none
module ttt_prescaler
    import ttt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic [5:0] i_prescale,
    output logic o_tick
);
    logic [15:0] cnt_r;
    logic [15:0] limit;

    assign limit = 16'((32'(i_prescale) + 32'd1) * TTT_TICK_UNIT - 1);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r <= TTT_RST16;
            o_tick <= 1'b0;
        end else if (!i_enable) begin
            cnt_r <= TTT_RST16;
            o_tick <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r <= TTT_RST16;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: ttt_timer_table.sv
// Timer table: register port, command, per-tick scan
`timescale 1ns/1ps
`default_nettype none
module ttt_timer_table
    import ttt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_busy,
    output logic [31:0] o_rdata,
    output logic o_irq
);
    typedef enum logic [1:0] {TTT_IDLE, TTT_SCAN, TTT_TALLY} ttt_state_e;

    ttt_state_e state_r;
    logic [15:0] events_r;
    logic [15:0] mask_r;
    logic [31:0] cmd_param_r;
    logic [6:0] config_r;
    logic [31:0] tally_r;
    logic [15:0] valid_r;
    logic [15:0] restart_r;
    logic cpm_mask_r;
    logic cpm_pend_r;
    logic [15:0] init_r [TTT_N];
    logic [15:0] cur_r [TTT_N];
    logic [3:0] idx_r;
    logic tick;
    logic tick_pend_r;
    logic [15:0] set_ev;
    logic [3:0] cmd_num;
    logic cmd_go;
    logic [3:0] reg_sel;
    logic [3:0] ent_sel;

    function automatic logic [15:0] ttt_load(input logic [15:0] period);
        ttt_load = period; // zero wraps to 0xffff on first decrement, so it times out like 65536
    endfunction

    assign reg_sel = i_addr[3:0];
    assign ent_sel = i_addr[7:4];
    assign cmd_num = cmd_param_r[TTT_P_NUM_LO +: 4];
    assign cmd_go = i_wr && reg_sel == TTT_A_CMD && i_wdata[15:0] == TTT_SET_TIMER;

    ttt_prescaler u_pre (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_enable(config_r[TTT_CFG_ENABLE]),
        .i_prescale(config_r[5:0]),
        .o_tick(tick)
    );

    // Timeout of the entry being scanned
    always_comb begin
        set_ev = 16'h0000;
        if (state_r == TTT_SCAN && !cmd_go && valid_r[idx_r] && cur_r[idx_r] == 16'h0001) begin
            set_ev[idx_r] = 1'b1;
        end
    end

    // Scan sequencer
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= TTT_IDLE;
            idx_r <= 4'h0;
            tick_pend_r <= 1'b0;
            tally_r <= TTT_RST32;
        end else begin
            if (tick) begin
                tick_pend_r <= 1'b1;
            end
            if (i_wr && reg_sel == TTT_A_TALLY) begin
                tally_r <= i_wdata;
            end
            case (state_r)
                TTT_IDLE: begin
                    if (tick_pend_r && !i_busy && !cmd_go) begin
                        tick_pend_r <= tick;
                        idx_r <= 4'h0;
                        state_r <= TTT_SCAN;
                    end
                end
                TTT_SCAN: begin
                    if (!cmd_go) begin
                        idx_r <= idx_r + 4'h1;
                        if (idx_r == 4'hf) begin
                            state_r <= TTT_TALLY;
                        end
                    end
                end
                TTT_TALLY: begin
                    tally_r <= tally_r + 32'h0000_0001;
                    state_r <= TTT_IDLE;
                end
                default: state_r <= TTT_IDLE;
            endcase
        end
    end

    // Timer entries, valid and mode bits
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            valid_r <= TTT_RST16;
            restart_r <= TTT_RST16;
            for (int i = 0; i < TTT_N; i++) begin
                init_r[i] <= TTT_RST16;
                cur_r[i] <= TTT_RST16;
            end
        end else if (cmd_go) begin
            valid_r[cmd_num] <= cmd_param_r[TTT_P_VALID];
            if (cmd_param_r[TTT_P_VALID]) begin
                restart_r[cmd_num] <= cmd_param_r[TTT_P_RESTART];
                init_r[cmd_num] <= ttt_load(cmd_param_r[15:0]);
                cur_r[cmd_num] <= ttt_load(cmd_param_r[15:0]);
            end
        end else if (state_r == TTT_SCAN && valid_r[idx_r]) begin
            if (set_ev[idx_r]) begin
                if (restart_r[idx_r]) begin
                    cur_r[idx_r] <= init_r[idx_r];
                end else begin
                    cur_r[idx_r] <= cur_r[idx_r] - 16'h0001;
                    valid_r[idx_r] <= 1'b0;
                end
            end else begin
                cur_r[idx_r] <= cur_r[idx_r] - 16'h0001;
            end
        end
    end

    // Event register, set wins over clear
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            events_r <= TTT_RST16;
        end else if (i_wr && reg_sel == TTT_A_EVENTS) begin
            events_r <= (events_r & ~i_wdata[15:0]) | set_ev;
        end else begin
            events_r <= events_r | set_ev;
        end
    end

    // Software registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_r <= TTT_RST16;
            cmd_param_r <= TTT_RST32;
            config_r <= TTT_RST_CFG;
            cpm_mask_r <= 1'b0;
        end else if (i_wr) begin
            case (reg_sel)
                TTT_A_MASK: mask_r <= i_wdata[15:0];
                TTT_A_CMD_PARAM: cmd_param_r <= i_wdata;
                TTT_A_CONFIG: config_r <= i_wdata[6:0];
                TTT_A_CPM_MASK: cpm_mask_r <= i_wdata[0];
                default: ;
            endcase
        end
    end

    // Module pending bit: set by any unmasked event, cleared by one
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cpm_pend_r <= 1'b0;
        end else if (|(events_r & mask_r)) begin
            cpm_pend_r <= 1'b1;
        end else if (i_wr && reg_sel == TTT_A_CPM_PEND && i_wdata[0]) begin
            cpm_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= cpm_pend_r && cpm_mask_r;
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= TTT_RST32;
        end else if (i_rd) begin
            case (reg_sel)
                TTT_A_EVENTS: o_rdata <= {16'h0000, events_r};
                TTT_A_MASK: o_rdata <= {16'h0000, mask_r};
                TTT_A_CMD_PARAM: o_rdata <= cmd_param_r;
                TTT_A_CONFIG: o_rdata <= {25'h0000000, config_r};
                TTT_A_TALLY: o_rdata <= tally_r;
                TTT_A_VALID: o_rdata <= {16'h0000, valid_r};
                TTT_A_RESTART: o_rdata <= {16'h0000, restart_r};
                TTT_A_CPM_MASK: o_rdata <= {31'h00000000, cpm_mask_r};
                TTT_A_CPM_PEND: o_rdata <= {31'h00000000, cpm_pend_r};
                TTT_A_ENTRY: o_rdata <= {init_r[ent_sel], cur_r[ent_sel]};
                default: o_rdata <= TTT_RST32;
            endcase
        end else begin
            o_rdata <= TTT_RST32;
        end
    end
endmodule
`default_nettype wire

// File: ttt_checker.sv
// Port assertions for the timer table
`timescale 1ns/1ps
`default_nettype none
module ttt_checker
    import ttt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_busy,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq
);
    logic mm_r;
    wire logic [3:0] a = i_addr[3:0];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // Last module mask bit written
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mm_r <= 1'b0;
        end else if (i_wr && a == TTT_A_CPM_MASK) begin
            mm_r <= i_wdata[0];
        end
    end
    property p_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_unmap; i_rd && a > TTT_A_ENTRY |=> o_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_upper; i_rd && a inside {4'h0, 4'h1, 4'h6, 4'h7} |=> o_rdata[31:16] == 16'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_mask; i_wr && a == TTT_A_MASK ##1 i_rd && a == TTT_A_MASK
        |=> o_rdata == ($past(i_wdata, 2) & 32'hffff); endproperty
    a_mask: assert property (p_mask) else $error("mask readback");
    property p_keep; i_rd && a == 4'h0 ##1 i_wr && a == 4'h0 && i_wdata[15:0] == 16'h0
        ##1 i_rd && a == 4'h0 |=> (o_rdata & $past(o_rdata, 2)) == $past(o_rdata, 2);
    endproperty
    a_keep: assert property (p_keep) else $error("zero write cleared");
    property p_mmask; i_wr && a == TTT_A_CPM_MASK ##1 i_rd && a == TTT_A_CPM_MASK
        |=> o_rdata == ($past(i_wdata, 2) & 32'h1); endproperty
    a_mmask: assert property (p_mmask) else $error("module mask");
    property p_gated; !mm_r && !$past(mm_r) |-> !o_irq; endproperty
    a_gated: assert property (p_gated) else $error("irq ungated");
    property p_off; i_wr && a == TTT_A_CPM_MASK && !i_wdata[0] |-> ##2 !o_irq; endproperty
    a_off: assert property (p_off) else $error("irq stays");
    c_busy: cover property (i_busy && o_irq);
    c_event: cover property (i_rd && a == TTT_A_EVENTS ##1 o_rdata[3]);
    c_cmd: cover property (i_wr && a == TTT_A_CMD && i_wdata[15:0] == TTT_SET_TIMER);
endmodule
bind ttt_timer_table ttt_checker i_ttt_checker (.i_core_clk, .i_nrst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_busy, .o_rdata, .o_irq);
`default_nettype wire

// File: ttt_tb.sv
// Self-checking bench for the timer table
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ttt_pkg::*;
;
    logic i_core_clk, i_nrst, i_wr, i_rd, i_busy, o_irq;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    int errors = 0;
    int total_checks = 0;
    ttt_timer_table i_ttt_timer_table (.i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .i_busy, .o_rdata, .o_irq);
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        op(1'b0, 1'b1, a, 32'h0);
        op(1'b0, 1'b0, 8'h0, 32'h0);
        #1 chk(n, e, o_rdata);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, {4'h0, a}, d);
    endtask
    task automatic t_reset;
        for (int k = 0; k < 10; k++) begin
            rdc("reset reg", k[7:0], 32'h0);
        end
        chk("irq", 32'h0, 32'(o_irq));
        $display("t_reset done");
    endtask
    task automatic t_regs;
        wr(TTT_A_MASK, 32'hffff_a5c3);
        rdc("mask", {4'h0, TTT_A_MASK}, 32'h0000_a5c3);
        wr(TTT_A_CPM_MASK, 32'h1);
        rdc("module mask", {4'h0, TTT_A_CPM_MASK}, 32'h1);
        rdc("unmapped", 8'h0c, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_scan;
        wr(TTT_A_EVENTS, 32'hffff);
        wr(TTT_A_MASK, 32'h8);
        wr(TTT_A_TALLY, 32'h0);
        wr(TTT_A_CMD_PARAM, 32'h8003_0002);
        wr(TTT_A_CMD, {16'h0, TTT_SET_TIMER});
        wr(TTT_A_CMD_PARAM, 32'hc005_0000);
        wr(TTT_A_CMD, {16'h0, TTT_SET_TIMER});
        wr(TTT_A_CMD_PARAM, 32'h8004_0001);
        wr(TTT_A_CMD, 32'h0861);
        rdc("valid", {4'h0, TTT_A_VALID}, 32'h28);
        rdc("restart", {4'h0, TTT_A_RESTART}, 32'h20);
        wr(TTT_A_CONFIG, 32'h40);
        op(1'b0, 1'b0, 8'h0, 32'h0);
        repeat (2200) @(posedge i_core_clk);
        i_busy <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        rdc("tally", {4'h0, TTT_A_TALLY}, 32'h2);
        rdc("events", {4'h0, TTT_A_EVENTS}, 32'h8);
        chk("irq", 32'h1, 32'(o_irq));
        rdc("valid", {4'h0, TTT_A_VALID}, 32'h20);
        rdc("entry", {4'h5, TTT_A_ENTRY}, 32'h0000_fffe);
        op(1'b0, 1'b1, 8'h0, 32'h0);
        op(1'b1, 1'b0, 8'h0, 32'h0);
        #1 chk("events", 32'h8, o_rdata);
        rdc("events", {4'h0, TTT_A_EVENTS}, 32'h8);
        wr(TTT_A_CPM_MASK, 32'h0);
        op(1'b0, 1'b0, 8'h0, 32'h0);
        @(posedge i_core_clk);
        #1 chk("irq", 32'h0, 32'(o_irq));
        wr(TTT_A_EVENTS, 32'h8);
        wr(TTT_A_CPM_PEND, 32'h1);
        wr(TTT_A_CPM_MASK, 32'h1);
        rdc("events", {4'h0, TTT_A_EVENTS}, 32'h0);
        chk("irq", 32'h0, 32'(o_irq));
        wr(TTT_A_CMD_PARAM, 32'h4005_1234);
        wr(TTT_A_CMD, {16'h0, TTT_SET_TIMER});
        rdc("valid", {4'h0, TTT_A_VALID}, 32'h0);
        rdc("restart", {4'h0, TTT_A_RESTART}, 32'h20);
        rdc("entry", {4'h5, TTT_A_ENTRY}, 32'h0000_fffe);
        @(posedge i_core_clk);
        i_busy <= 1'b0;
        $display("t_scan done");
    endtask
    initial begin
        i_nrst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_busy = 1'b0;
        i_addr = 8'h0;
        i_wdata = 32'h0;
        repeat (10) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_reset;
        t_regs;
        t_scan;
        end_sim;
    end
    initial begin
        repeat (10000) @(posedge i_core_clk);
        errors++;
        end_sim;
    end
endmodule
`default_nettype wire
